// [inc/acslc_map.svh]
// address map, field positions, reset values and device addresses
`ifndef ACSLC_MAP_SVH
`define ACSLC_MAP_SVH

// controller register offsets on the software port
`define ACSLC_SW_CHAN      4'h0
`define ACSLC_SW_UPPER     4'h1
`define ACSLC_SW_LOWER     4'h2
`define ACSLC_SW_TARGET    4'h3
`define ACSLC_SW_CMD       4'h4
`define ACSLC_SW_ERR       4'h5
`define ACSLC_SW_READBACK  4'h6

// device register addresses
`define ACSLC_DEV_UPPER    20'hF0011
`define ACSLC_DEV_LOWER    20'hF0012
`define ACSLC_DEV_TARGET   20'hF0013
`define ACSLC_DEV_CHAN     20'hFFF31

// reset values
`define ACSLC_UPPER_RST    8'hFF
`define ACSLC_LOWER_RST    8'h00
`define ACSLC_CHAN_RST     8'h00
`define ACSLC_TARGET_RST   2'h0

// channel register fields
`define ACSLC_CH_INT_BIT   7
`define ACSLC_CH_SCAN_BIT  6
`define ACSLC_CH_CODE_HI   4

// channel code limits
`define ACSLC_SEL_LOW_MAX  5'h0E
`define ACSLC_SEL_GAP      5'h0F
`define ACSLC_SEL_HIGH_MAX 5'h1A
`define ACSLC_SCAN_MAX     5'h0B
`define ACSLC_SCAN_SLOTS   4
`define ACSLC_CH_PLUS_PIN  5'h00
`define ACSLC_CH_MINUS_PIN 5'h01

// command bits and status bits
`define ACSLC_CMD_GO       0
`define ACSLC_CMD_ACK      1
`define ACSLC_ST_BUSY      0
`define ACSLC_ST_DISCARD   1
`define ACSLC_ST_REFUSED   2

// error cause bits
`define ACSLC_ERR_RUN      0
`define ACSLC_ERR_ORDER    1
`define ACSLC_ERR_SPEED    2
`define ACSLC_ERR_REF      3
`define ACSLC_ERR_LOWPOW   4
`define ACSLC_ERR_PIN      5
`define ACSLC_ERR_W        6

// status input bit positions in the synchronised vector
`define ACSLC_IN_CONVERSION_START_FLAG      0
`define ACSLC_IN_CONVERTER_ENABLE_FLAG      1
`define ACSLC_IN_HS        2
`define ACSLC_IN_EXTP      3
`define ACSLC_IN_EXTM      4
`define ACSLC_IN_PINT      5
`define ACSLC_IN_LOWPOW    6
`define ACSLC_IN_FLAGS     7

`endif

// [inc/acslc_pkg.sv]
// types shared by the converter control host
package acslc_pkg;

  typedef enum logic [7:0] {
    ST_IDLE    = 8'h01,
    ST_WR_UP   = 8'h02,
    ST_WR_LO   = 8'h04,
    ST_WR_TGT  = 8'h08,
    ST_WR_CHAN = 8'h10,
    ST_RD_CHAN = 8'h20,
    ST_RD_WAIT = 8'h40,
    ST_CAPT    = 8'h80
  } acslc_state_t;

endpackage

// [test/acslc_dev_model.sv]
// register model of the converter device behind the host's device port
`timescale 1ns/1ps
`include "acslc_map.svh"

module acslc_dev_model (
  input  wire logic        CLOCK,
  input  wire logic        RST,
  input  wire logic [19:0] DEV_ADDR,
  input  wire logic [7:0]  DEV_WDATA,
  input  wire logic        DEV_WR,
  input  wire logic        DEV_RD,
  output logic      [7:0]  DEV_RDATA
);
  logic [7:0] upper_q, lower_q, target_q, chan_q, rdata_q;
  logic       valid_q;

  // data is only good in the answer cycle; garbled otherwise so a late
  // sample by the host cannot pass by luck
  assign DEV_RDATA = valid_q ? rdata_q : ~rdata_q;

  // reset values, then every write stored as written, prohibited codes too
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      upper_q  <= `ACSLC_UPPER_RST;
      lower_q  <= `ACSLC_LOWER_RST;
      target_q <= 8'h00;
      chan_q   <= `ACSLC_CHAN_RST;
      rdata_q  <= 8'h00;
      valid_q  <= 1'b0;
    end else begin
      valid_q <= DEV_RD;
      if (DEV_RD) rdata_q <= chan_q;
      if (DEV_WR && DEV_ADDR == `ACSLC_DEV_UPPER) upper_q <= DEV_WDATA;
      if (DEV_WR && DEV_ADDR == `ACSLC_DEV_LOWER) lower_q <= DEV_WDATA;
      if (DEV_WR && DEV_ADDR == `ACSLC_DEV_TARGET) target_q <= DEV_WDATA;
      if (DEV_WR && DEV_ADDR == `ACSLC_DEV_CHAN) chan_q <= DEV_WDATA;
    end
  end
endmodule // acslc_dev_model

// [test/acslc_host_checker.sv]
// concurrent checks on the converter host's device port
`timescale 1ns/1ps
`include "acslc_map.svh"

module acslc_host_checker #(
  parameter int PINS = 27
) (
  input wire logic            CLOCK,
  input wire logic            RST,
  input wire logic [19:0]     DEV_ADDR,
  input wire logic [7:0]      DEV_WDATA,
  input wire logic            DEV_WR,
  input wire logic            DEV_RD,
  input wire logic            CONV_START_FLAG,
  input wire logic            CONV_ENABLE_FLAG,
  input wire logic [PINS-1:0] ANALOG_PIN_READY
);
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (RST);

  // a channel write to the device, decoded once for several properties
  wire       chan_wr = DEV_WR && DEV_ADDR == `ACSLC_DEV_CHAN;
  wire [4:0] code    = DEV_WDATA[4:0];

  a_upper_first: assert property ($rose(DEV_WR) |-> DEV_ADDR == `ACSLC_DEV_UPPER)
    else $error("burst does not open with the upper limit");
  a_lower_next: assert property ($rose(DEV_WR) |-> ##1 DEV_WR && DEV_ADDR == `ACSLC_DEV_LOWER)
    else $error("lower limit not second");
  a_target_field: assert property ($rose(DEV_WR) |-> ##2 DEV_WR && DEV_ADDR == `ACSLC_DEV_TARGET && DEV_WDATA[7:2] == 6'h00)
    else $error("target write misplaced or padded wrong");
  a_chan_readback: assert property ($rose(DEV_WR) |-> ##3 chan_wr ##1 (DEV_RD && !DEV_WR && DEV_ADDR == `ACSLC_DEV_CHAN) ##1 !DEV_RD)
    else $error("channel write or readback out of order");
  a_burst_length: assert property ($rose(DEV_WR) |-> DEV_WR [*4] ##1 !DEV_WR)
    else $error("device write burst not four long");
  a_chan_pad: assert property (chan_wr |-> DEV_WDATA[6:5] == 2'b00)
    else $error("channel bits 5 and 6 not zero");
  a_stopped_go: assert property ($rose(DEV_WR) |-> !$past(CONV_START_FLAG, 4) && !$past(CONV_ENABLE_FLAG, 4))
    else $error("device written while converter running");
  a_pin_ready: assert property (chan_wr && !DEV_WDATA[7] && code <= 5'h1A && code != 5'h0F |-> ANALOG_PIN_READY[code])
    else $error("channel names a pin not set up as analog");
endmodule // acslc_host_checker

bind acslc_host acslc_host_checker #(.PINS(PINS)) u_checker (
  .CLOCK(CLOCK), .RST(RST), .DEV_ADDR(DEV_ADDR), .DEV_WDATA(DEV_WDATA),
  .DEV_WR(DEV_WR), .DEV_RD(DEV_RD), .CONV_START_FLAG(CONV_START_FLAG),
  .CONV_ENABLE_FLAG(CONV_ENABLE_FLAG), .ANALOG_PIN_READY(ANALOG_PIN_READY));

// [test/testbench.sv]
// self-checking bench for the converter host controller
`timescale 1ns/1ps

module testbench;
  logic        clock, rst, sw_wr, sw_rd, dev_wr, dev_rd;
  logic [3:0]  sw_addr;
  logic [7:0]  sw_wdata, sw_rdata, dev_wdata, dev_rdata, v, old;
  logic [19:0] dev_addr;
  logic [6:0]  cond;
  logic [26:0] pins;
  int          errors, samples_checked;
  logic [7:0]  ch_tab [8] = '{8'h00, 8'h0E, 8'h0F, 8'h10,
                              8'h1A, 8'h1B, 8'h4B, 8'h81};
  logic [1:0]  tg_tab [4] = '{2'h0, 2'h2, 2'h3, 2'h1};

  acslc_host #(.PINS(27)) DUT (.CLOCK(clock), .RST(rst), .SW_ADDR(sw_addr),
    .SW_WDATA(sw_wdata), .SW_WR(sw_wr), .SW_RD(sw_rd), .SW_RDATA(sw_rdata),
    .DEV_ADDR(dev_addr), .DEV_WDATA(dev_wdata), .DEV_WR(dev_wr),
    .DEV_RD(dev_rd), .DEV_RDATA(dev_rdata), .CONV_START_FLAG(cond[0]),
    .CONV_ENABLE_FLAG(cond[1]), .HIGH_SPEED_MAIN_OP(cond[2]),
    .EXT_PLUS_REF_USED(cond[3]), .EXT_MINUS_REF_USED(cond[4]),
    .PLUS_REF_INTERNAL(cond[5]), .LOW_POWER_ENTRY(cond[6]),
    .ANALOG_PIN_READY(pins));
  acslc_dev_model model (.CLOCK(clock), .RST(rst), .DEV_ADDR(dev_addr),
    .DEV_WDATA(dev_wdata), .DEV_WR(dev_wr), .DEV_RD(dev_rd),
    .DEV_RDATA(dev_rdata));

  always #2.5 clock = ~clock;

  // bus cycles; the write strobe is left high until the next call changes it, rd drops its own
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    sw_addr  <= a;
    sw_wdata <= d;
    sw_rd    <= 1'b0;
    sw_wr    <= 1'b1;
    @(posedge clock);
  endtask

  task automatic tick(input int n);
    sw_wr <= 1'b0;
    sw_rd <= 1'b0;
    repeat (n) @(posedge clock);
  endtask

  // read data stands only in the cycle after the strobe
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    sw_addr <= a;
    sw_wr   <= 1'b0;
    sw_rd   <= 1'b1;
    @(posedge clock);
    sw_rd   <= 1'b0;
    @(negedge clock);
    d = sw_rdata;
    @(posedge clock);
  endtask

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic prog(input logic [7:0] c, u, l, input logic [1:0] t);
    wr(4'h0, c);
    wr(4'h1, u);
    wr(4'h2, l);
    wr(4'h3, {6'h00, t});
  endtask

  // the device sequence is fixed at seven busy cycles, so no polling is needed
  task automatic go();
    wr(4'h4, 8'h01);
    tick(8);
    rd(4'h4, v);
  endtask

  // a refused go: cause reported, device upper limit register left alone
  task automatic refuse(input logic [6:0] c, input logic [26:0] p,
                        input logic [7:0] ch, u, e);
    cond <= c;
    pins <= p;
    prog(ch, u, 8'h10, 2'h0);
    old = model.upper_q;
    go();
    chk(v & 8'h05, 8'h04);
    rd(4'h5, v);
    chk(v, e);
    chk(model.upper_q, old);
  endtask

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  // watchdog: the whole sequence needs well under a thousand cycles
  initial begin
    repeat (5000) @(posedge clock);
    errors++;
    end_of_test();
  end

  initial begin
    {clock, sw_wr, sw_rd, sw_addr, sw_wdata} = '0;
    rst  = 1'b1;
    cond = 7'h04;
    pins = '1;
    repeat (3) @(posedge clock);
    rst <= 1'b0;
    tick(2);
    rd(4'h0, v); chk(v, 8'h00);
    rd(4'h1, v); chk(v, 8'hFF);
    rd(4'h2, v); chk(v, 8'h00);
    rd(4'h3, v); chk(v, 8'h00);
    rd(4'hF, v); chk(v, 8'h00);
    $display("test reset_values done");
    for (int i = 0; i < 8; i++) begin
      prog(ch_tab[i], 8'h90 | 8'(i), 8'h10 | 8'(i), tg_tab[i % 4]);
      go();
      chk(v & 8'h01, 8'h00);
      chk(model.chan_q, ch_tab[i] & 8'h9F);
      chk(model.upper_q, 8'h90 | 8'(i));
      chk(model.lower_q, 8'h10 | 8'(i));
      chk(model.target_q, {6'h00, tg_tab[i % 4]});
      rd(4'h6, v); chk(v, ch_tab[i] & 8'h9F);
    end
    rd(4'h4, v); chk(v & 8'h03, 8'h02);
    wr(4'h4, 8'h02);
    rd(4'h4, v); chk(v & 8'h02, 8'h00);
    $display("test channel_codes done");
    refuse(7'h06, '1, 8'h02, 8'h55, 8'h01);
    refuse(7'h05, '1, 8'h02, 8'h55, 8'h01);
    refuse(7'h04, '1, 8'h02, 8'h10, 8'h02);
    refuse(7'h00, '1, 8'h81, 8'h55, 8'h04);
    refuse(7'h0C, '1, 8'h00, 8'h55, 8'h08);
    refuse(7'h14, '1, 8'h01, 8'h55, 8'h08);
    refuse(7'h24, '1, 8'h81, 8'h55, 8'h08);
    refuse(7'h44, '1, 8'h81, 8'h55, 8'h10);
    refuse(7'h04, 27'h7FFFFF7, 8'h43, 8'h55, 8'h20);
    refuse(7'h04, 27'h7FEFFFF, 8'h10, 8'h55, 8'h20);
    cond <= 7'h04;
    pins <= '1;
    prog(8'h05, 8'hA0, 8'h20, 2'h0);
    wr(4'h4, 8'h01);
    wr(4'h1, 8'h33);
    tick(8);
    rd(4'h5, v); chk(v, 8'h00);
    rd(4'h1, v); chk(v, 8'hA0);
    chk(model.upper_q, 8'hA0);
    $display("test refusals done");
    end_of_test();
  end
endmodule // testbench

// [verilog/acslc_host.sv]
// host controller that programs the converter channel and limit registers
//
// Decided for this implementation: the plain strobed port.
`timescale 1ns/1ps
`include "acslc_map.svh"

module acslc_host #(
  parameter int PINS = 27
) (
  input  wire logic             CLOCK,
  input  wire logic             RST,
  input  wire logic [3:0]       SW_ADDR,
  input  wire logic [7:0]       SW_WDATA,
  input  wire logic             SW_WR,
  input  wire logic             SW_RD,
  output logic      [7:0]       SW_RDATA,
  output logic      [19:0]      DEV_ADDR,
  output logic      [7:0]       DEV_WDATA,
  output logic                  DEV_WR,
  output logic                  DEV_RD,
  input  wire logic [7:0]       DEV_RDATA,
  input  wire logic             CONV_START_FLAG,
  input  wire logic             CONV_ENABLE_FLAG,
  input  wire logic             HIGH_SPEED_MAIN_OP,
  input  wire logic             EXT_PLUS_REF_USED,
  input  wire logic             EXT_MINUS_REF_USED,
  input  wire logic             PLUS_REF_INTERNAL,
  input  wire logic             LOW_POWER_ENTRY,
  input  wire logic [PINS-1:0]  ANALOG_PIN_READY
);

  localparam int SYNW = `ACSLC_IN_FLAGS + PINS;

  acslc_pkg::acslc_state_t state_q;
  acslc_pkg::acslc_state_t state_d;

  logic [SYNW-1:0]            meta_q;
  logic [SYNW-1:0]            sync_q;
  logic [7:0]                 chan_q;
  logic [7:0]                 upper_q;
  logic [7:0]                 lower_q;
  logic [1:0]                 target_q;
  logic                       discard_q;
  logic                       refused_q;
  logic [`ACSLC_ERR_W-1:0]    err_q;
  logic [7:0]                 readback_q;
  logic [7:0]                 rdata_q;
  logic [19:0]                dev_addr_q;
  logic [19:0]                dev_addr_d;
  logic [7:0]                 dev_wdata_q;
  logic [7:0]                 dev_wdata_d;
  logic                       dev_wr_q;
  logic                       dev_wr_d;
  logic                       dev_rd_q;
  logic                       dev_rd_d;

  // pin levels come from another domain: two flops before any use
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= {ANALOG_PIN_READY, LOW_POWER_ENTRY, PLUS_REF_INTERNAL,
                 EXT_MINUS_REF_USED, EXT_PLUS_REF_USED,
                 HIGH_SPEED_MAIN_OP, CONV_ENABLE_FLAG, CONV_START_FLAG};
      sync_q <= meta_q;
    end
  end

  // decoded views of the synchronised inputs and the channel setting
  wire        idle_w     = (state_q == acslc_pkg::ST_IDLE);
  wire        conversion_start_flag_w     = sync_q[`ACSLC_IN_CONVERSION_START_FLAG];
  wire        converter_enable_flag_w     = sync_q[`ACSLC_IN_CONVERTER_ENABLE_FLAG];
  wire        hs_w       = sync_q[`ACSLC_IN_HS];
  wire        extp_w     = sync_q[`ACSLC_IN_EXTP];
  wire        extm_w     = sync_q[`ACSLC_IN_EXTM];
  wire        pint_w     = sync_q[`ACSLC_IN_PINT];
  wire        lowpow_w   = sync_q[`ACSLC_IN_LOWPOW];
  wire [31:0] pin_ok_w   = 32'(sync_q[SYNW-1:`ACSLC_IN_FLAGS]);
  wire        internal_w = chan_q[`ACSLC_CH_INT_BIT];
  wire        scan_w     = chan_q[`ACSLC_CH_SCAN_BIT];
  wire [4:0]  code_w     = chan_q[`ACSLC_CH_CODE_HI:0];

  // software port decode
  wire sw_wr_cfg_w = SW_WR && idle_w;
  wire go_w        = SW_WR && (SW_ADDR == `ACSLC_SW_CMD)
                     && SW_WDATA[`ACSLC_CMD_GO];
  wire ack_w       = SW_WR && (SW_ADDR == `ACSLC_SW_CMD)
                     && SW_WDATA[`ACSLC_CMD_ACK];

  // which codes name a real external input; others pass unchecked
  wire sel_real_w  = (code_w <= `ACSLC_SEL_HIGH_MAX)
                     && (code_w != `ACSLC_SEL_GAP);
  wire scan_real_w = (code_w <= `ACSLC_SCAN_MAX);

  // per scan slot: channel number, pin readiness, reference pin clash
  logic [`ACSLC_SCAN_SLOTS-1:0] slot_bad_w;
  logic [`ACSLC_SCAN_SLOTS-1:0] slot_p_w;
  logic [`ACSLC_SCAN_SLOTS-1:0] slot_m_w;
  for (genvar i = 0; i < `ACSLC_SCAN_SLOTS; i++) begin : g_slot
    wire [4:0] ch_w = code_w + 5'(i);
    wire       use_w = (i == 0) ? sel_real_w || scan_w && scan_real_w
                                : scan_w && scan_real_w;
    assign slot_bad_w[i] = use_w && !pin_ok_w[ch_w];
    assign slot_p_w[i]   = use_w && (ch_w == `ACSLC_CH_PLUS_PIN);
    assign slot_m_w[i]   = use_w && (ch_w == `ACSLC_CH_MINUS_PIN);
  end

  // checks made before the device is touched; a failed one refuses go
  logic [`ACSLC_ERR_W-1:0] err_w;
  assign err_w[`ACSLC_ERR_RUN]    = conversion_start_flag_w || converter_enable_flag_w;
  assign err_w[`ACSLC_ERR_ORDER]  = upper_q <= lower_q;
  assign err_w[`ACSLC_ERR_SPEED]  = internal_w && !hs_w;
  assign err_w[`ACSLC_ERR_REF]    = internal_w ? pint_w
                                    : (extp_w && |slot_p_w)
                                      || (extm_w && |slot_m_w);
  assign err_w[`ACSLC_ERR_LOWPOW] = internal_w && lowpow_w;
  assign err_w[`ACSLC_ERR_PIN]    = !internal_w && |slot_bad_w;
  wire go_ok_w = go_w && idle_w && (err_w == '0);

  // channel byte as sent: bits 5 and 6 forced to zero
  wire [7:0] chan_dev_w = {internal_w, 2'b00, code_w};

  // sequencer: upper, lower, target, channel, then read channel back
  always_comb begin
    state_d     = state_q;
    dev_addr_d  = dev_addr_q;
    dev_wdata_d = dev_wdata_q;
    dev_wr_d    = 1'b0;
    dev_rd_d    = 1'b0;
    case (state_q)
      acslc_pkg::ST_IDLE: begin
        if (go_ok_w) begin
          state_d = acslc_pkg::ST_WR_UP;
        end
      end
      acslc_pkg::ST_WR_UP: begin
        dev_addr_d  = `ACSLC_DEV_UPPER;
        dev_wdata_d = upper_q;
        dev_wr_d    = 1'b1;
        state_d     = acslc_pkg::ST_WR_LO;
      end
      acslc_pkg::ST_WR_LO: begin
        dev_addr_d  = `ACSLC_DEV_LOWER;
        dev_wdata_d = lower_q;
        dev_wr_d    = 1'b1;
        state_d     = acslc_pkg::ST_WR_TGT;
      end
      acslc_pkg::ST_WR_TGT: begin
        dev_addr_d  = `ACSLC_DEV_TARGET;
        dev_wdata_d = {6'h00, target_q};
        dev_wr_d    = 1'b1;
        state_d     = acslc_pkg::ST_WR_CHAN;
      end
      acslc_pkg::ST_WR_CHAN: begin
        dev_addr_d  = `ACSLC_DEV_CHAN;
        dev_wdata_d = chan_dev_w;
        dev_wr_d    = 1'b1;
        state_d     = acslc_pkg::ST_RD_CHAN;
      end
      acslc_pkg::ST_RD_CHAN: begin
        dev_addr_d  = `ACSLC_DEV_CHAN;
        dev_rd_d    = 1'b1;
        state_d     = acslc_pkg::ST_RD_WAIT;
      end
      acslc_pkg::ST_RD_WAIT: begin
        state_d     = acslc_pkg::ST_CAPT;               // strobe on the pins
      end
      acslc_pkg::ST_CAPT: begin
        state_d     = acslc_pkg::ST_IDLE;               // read data now valid
      end
      default: begin
        state_d     = acslc_pkg::ST_IDLE;
      end
    endcase
  end

  // state and device bus flops
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      state_q     <= acslc_pkg::ST_IDLE;
      dev_addr_q  <= '0;
      dev_wdata_q <= '0;
      dev_wr_q    <= 1'b0;
      dev_rd_q    <= 1'b0;
    end else begin
      state_q     <= state_d;
      dev_addr_q  <= dev_addr_d;
      dev_wdata_q <= dev_wdata_d;
      dev_wr_q    <= dev_wr_d;
      dev_rd_q    <= dev_rd_d;
    end
  end

  // configuration shadows; writes while busy are dropped so the
  // sequence never sends a half-updated set
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      chan_q   <= `ACSLC_CHAN_RST;
      upper_q  <= `ACSLC_UPPER_RST;
      lower_q  <= `ACSLC_LOWER_RST;
      target_q <= `ACSLC_TARGET_RST;
    end else if (sw_wr_cfg_w) begin
      if (SW_ADDR == `ACSLC_SW_CHAN) begin
        chan_q <= SW_WDATA & 8'hDF;
      end
      if (SW_ADDR == `ACSLC_SW_UPPER) begin
        upper_q <= SW_WDATA;
      end
      if (SW_ADDR == `ACSLC_SW_LOWER) begin
        lower_q <= SW_WDATA;
      end
      if (SW_ADDR == `ACSLC_SW_TARGET) begin
        target_q <= SW_WDATA[1:0];
      end
    end
  end

  // discard flag: set when an internal source goes out, set beats ack
  wire discard_set_w = (state_q == acslc_pkg::ST_WR_CHAN) && internal_w;
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      discard_q <= 1'b0;
    end else if (discard_set_w) begin
      discard_q <= 1'b1;
    end else if (ack_w) begin
      discard_q <= 1'b0;
    end
  end

  // outcome of the last go command
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      refused_q <= 1'b0;
      err_q     <= '0;
    end else if (go_w && idle_w) begin
      refused_q <= (err_w != '0);
      err_q     <= err_w;
    end
  end

  // channel register as read back from the device
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      readback_q <= '0;
    end else if (state_q == acslc_pkg::ST_CAPT) begin
      readback_q <= DEV_RDATA;
    end
  end

  // read mux; unmapped offsets read zero
  logic [7:0] rmux_w;
  always_comb begin
    case (SW_ADDR)
      `ACSLC_SW_CHAN:     rmux_w = chan_q;
      `ACSLC_SW_UPPER:    rmux_w = upper_q;
      `ACSLC_SW_LOWER:    rmux_w = lower_q;
      `ACSLC_SW_TARGET:   rmux_w = {6'h00, target_q};
      `ACSLC_SW_CMD:      rmux_w = {5'h00, refused_q, discard_q, !idle_w};
      `ACSLC_SW_ERR:      rmux_w = 8'(err_q);
      `ACSLC_SW_READBACK: rmux_w = readback_q;
      default:            rmux_w = 8'h00;
    endcase
  end

  // read data stands only in the cycle after the strobe
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      rdata_q <= 8'h00;
    end else begin
      rdata_q <= SW_RD ? rmux_w : 8'h00;
    end
  end

  assign SW_RDATA  = rdata_q;
  assign DEV_ADDR  = dev_addr_q;
  assign DEV_WDATA = dev_wdata_q;
  assign DEV_WR    = dev_wr_q;
  assign DEV_RD    = dev_rd_q;

endmodule // acslc_host
